/* File: core/nva_consts.svh */
// Constants for the nonvolatile data access block: offsets, fields, keys.
// Assumes inclusion by bare name from the package and the design files.
`ifndef NVA_CONSTS_SVH
`define NVA_CONSTS_SVH

// Register byte offsets on the APB
`define NVA_OFS_DATA     8'h00
`define NVA_OFS_LOCATION 8'h04
`define NVA_OFS_CONTROL  8'h08
`define NVA_OFS_UNLOCK   8'h0C
`define NVA_OFS_IRQFLAGS 8'h10

// Control register fields
`define NVA_CTL_FETCH    0
`define NVA_CTL_PROGRAM  1
`define NVA_CTL_PERMIT   2
`define NVA_CTL_ABORT    3
// Peripheral interrupt flag position
`define NVA_IRQ_DONE     7

// Reset and erased byte values
`define NVA_RST_BYTE     8'h00
`define NVA_ERASED_BYTE  8'hFF

// Unlock keys and the longest gap between two sequence steps
`define NVA_UNLOCK_KEY1  8'h55
`define NVA_UNLOCK_KEY2  8'hAA
`define NVA_UNLOCK_GAP   4'h8

// Timing
`define NVA_CLK_PERIOD_NS 100
`define NVA_PWRT_US       64000
`define NVA_WRITE_CYCLES  64

`endif

/* File: core/nva_pkg.sv */
// Types shared by the nonvolatile data access block.
// Assumes nva_consts.svh is on the include path.
`include "nva_consts.svh"

package nva_pkg;
   typedef enum logic [1:0] {
      NVA_ULK_IDLE  = 2'b00,
      NVA_ULK_SAW1  = 2'b01,
      NVA_ULK_ARMED = 2'b10
   } nva_ulk_t;

   typedef enum logic [1:0] {
      NVA_WR_IDLE  = 2'b00,
      NVA_WR_ERASE = 2'b01,
      NVA_WR_PROG  = 2'b10
   } nva_wr_t;

   typedef logic [7:0] nva_byte_t;
endpackage : nva_pkg

/* File: core/nva_array.sv */
// Byte array of the nonvolatile store, one write port, two read ports.
// Assumes the caller sequences erase and program on the write port.
`timescale 1ns/100ps
`default_nettype none

module nva_array #(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic              clk_sys,    // System clock
   input  wire logic              we,         // Write strobe
   input  wire logic [AW-1:0]     wr_addr,    // Write location
   input  wire nva_pkg::nva_byte_t wr_data,   // Write byte
   input  wire logic [AW-1:0]     rd_addr_a,  // CPU read location
   output var  nva_pkg::nva_byte_t rd_data_a, // CPU read byte
   input  wire logic [AW-1:0]     rd_addr_b,  // Programmer read location
   output var  nva_pkg::nva_byte_t rd_data_b  // Programmer read byte
);
   import nva_pkg::*;

   nva_byte_t mem_ff [DEPTH];

   // Cells hold no reset: their content is nonvolatile
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_cell
         always_ff @(posedge clk_sys) begin
            if (we && (wr_addr == AW'(i))) begin
               mem_ff[i] <= wr_data;
            end
         end
      end
   endgenerate

   assign rd_data_a = mem_ff[rd_addr_a];
   assign rd_data_b = mem_ff[rd_addr_b];
endmodule : nva_array

`default_nettype wire

/* File: core/nva_top.sv */
// APB-mapped access logic for a 256-byte nonvolatile data store.
// Assumes an APB master on clk_sys and reset events from the reset block.
//
// Contract
// - 256 bytes selected by full location byte
// - Eight-bit data register for read and write
// - Byte write erases, then programs automatically
// - Write cycle length set by internal timer
// - Protected: CPU normal, programmer reads zeroes
// - Control bits 7-4 ignore writes, read zero
// - Launch bits set-only, cleared by hardware
// - Permit bit gates writes, clear after power-up
// - Abort flag set when reset cuts write
// - Aborting reset clears data and location
// - Write completion sets sticky done flag
// - Unlock port stores nothing, reads zero
// - Fetch takes one cycle into data register
// - Data register holds until read or write
// - Write needs 55h, AAh, launch in order
// - Launch ignored while permit is clear
// - Hardware never clears permit; write continues
// - No writes while power-up timer runs
`timescale 1ns/100ps
`default_nettype none
`include "nva_consts.svh"

module nva_top #(
   parameter int AW           = 8,
   parameter int DEPTH        = 256,
   parameter int WRITE_CYCLES = `NVA_WRITE_CYCLES,
   parameter int PWRT_CYCLES  = `NVA_PWRT_US * 1000 / `NVA_CLK_PERIOD_NS
) (
   input  wire logic              clk_sys,          // System clock
   input  wire logic              rst,              // Power-on reset
   input  wire logic              psel,             // APB select
   input  wire logic              penable,          // APB enable
   input  wire logic              pwrite,           // APB direction
   input  wire logic [7:0]        paddr,            // APB byte address
   input  wire logic [31:0]       pwdata,           // APB write data
   output logic [31:0]            prdata,           // APB read data
   output logic                   pready,           // APB ready
   output logic                   pslverr,          // APB error
   input  wire logic              master_clear_reset,     // Reset event
   input  wire logic              watchdog_timeout_reset, // Reset event
   input  wire logic              brownout_reset,         // Reset event
   input  wire logic              cpu_sleep,        // Core is asleep
   input  wire logic              data_protect_pin, // Protect strap
   input  wire logic [AW-1:0]     pgm_addr_pin,     // Programmer address
   output nva_pkg::nva_byte_t     pgm_rdata,        // Programmer data
   output logic                   nv_done_irq_flag, // Write done flag
   output logic                   write_busy        // Write in progress
);
   import nva_pkg::*;

   localparam int ERASE_CYC = (WRITE_CYCLES / 2 < 1) ? 1 : WRITE_CYCLES / 2;
   localparam int PROG_CYC  = (WRITE_CYCLES - ERASE_CYC < 1) ? 1 :
                              WRITE_CYCLES - ERASE_CYC;
   localparam int CW        = $clog2(WRITE_CYCLES + 1) + 1;
   localparam int PW        = $clog2(PWRT_CYCLES + 1);

   // Register state
   nva_byte_t   data_ff;
   logic [AW-1:0] loc_ff;
   logic        fetch_ff;
   logic        launch_ff;
   logic        permit_ff;
   logic        abort_ff;
   logic        done_flag_ff;
   // Bus state
   logic        pready_ff;
   logic        pslverr_ff;
   logic [31:0] prdata_ff;
   // Sequencers
   nva_ulk_t    ulk_ff;
   nva_ulk_t    nxt_ulk;
   logic [3:0]  ulk_gap_ff;
   nva_wr_t     wr_ff;
   logic [CW-1:0] wcnt_ff;
   logic [AW-1:0] wa_ff;
   nva_byte_t   wd_ff;
   logic [PW-1:0] pwrt_ff;
   // Pin synchronisers and programmer port
   logic        prot_s1_ff;
   logic        prot_s2_ff;
   logic [AW-1:0] pga_s1_ff;
   logic [AW-1:0] pga_s2_ff;
   nva_byte_t   pgm_rdata_ff;

   logic        setup;
   logic        acc_wr;
   logic        mapped;
   logic        wr_data;
   logic        wr_loc;
   logic        wr_ctl;
   logic        wr_ulk;
   logic        wr_irq;
   logic        evt;
   logic        launch;
   logic        done;
   logic        arr_we;
   nva_byte_t   arr_wdata;
   nva_byte_t   arr_rd_a;
   nva_byte_t   arr_rd_b;
   logic [31:0] rd_mux;

   // Bus decode
   assign setup  = psel && !penable;
   assign mapped = (paddr == `NVA_OFS_DATA) || (paddr == `NVA_OFS_LOCATION) ||
                   (paddr == `NVA_OFS_CONTROL) ||
                   (paddr == `NVA_OFS_UNLOCK) ||
                   (paddr == `NVA_OFS_IRQFLAGS);
   assign acc_wr = psel && penable && pready_ff && pwrite && !pslverr_ff;
   assign wr_data = acc_wr && (paddr == `NVA_OFS_DATA);
   assign wr_loc  = acc_wr && (paddr == `NVA_OFS_LOCATION);
   assign wr_ctl  = acc_wr && (paddr == `NVA_OFS_CONTROL);
   assign wr_ulk  = acc_wr && (paddr == `NVA_OFS_UNLOCK);
   assign wr_irq  = acc_wr && (paddr == `NVA_OFS_IRQFLAGS);

   // Watchdog only resets while the core is awake
   assign evt = master_clear_reset || brownout_reset ||
                (watchdog_timeout_reset && !cpu_sleep);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `NVA_OFS_DATA:     rd_mux[7:0] = data_ff;
         `NVA_OFS_LOCATION: rd_mux[AW-1:0] = loc_ff;
         `NVA_OFS_CONTROL: begin
            rd_mux[`NVA_CTL_FETCH]   = fetch_ff;
            rd_mux[`NVA_CTL_PROGRAM] = launch_ff;
            rd_mux[`NVA_CTL_PERMIT]  = permit_ff;
            rd_mux[`NVA_CTL_ABORT]   = abort_ff;
         end
         `NVA_OFS_IRQFLAGS: rd_mux[`NVA_IRQ_DONE] = done_flag_ff;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // One wait-free access phase per transfer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup && !mapped;
         if (setup) begin
            prdata_ff <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
         end
      end
   end

   // Data register
   always_ff @(posedge clk_sys) begin
      if (rst || evt) begin
         data_ff <= `NVA_RST_BYTE;
      end else if (fetch_ff) begin
         data_ff <= arr_rd_a;
      end else if (wr_data) begin
         data_ff <= pwdata[7:0];
      end
   end

   // Location register
   always_ff @(posedge clk_sys) begin
      if (rst || evt) begin
         loc_ff <= AW'(`NVA_RST_BYTE);
      end else if (wr_loc) begin
         loc_ff <= pwdata[AW-1:0];
      end
   end

   // Fetch launch: set-only, cleared one cycle later
   always_ff @(posedge clk_sys) begin
      if (rst || evt) begin
         fetch_ff <= 1'b0;
      end else if (fetch_ff) begin
         fetch_ff <= 1'b0;
      end else if (wr_ctl && pwdata[`NVA_CTL_FETCH]) begin
         fetch_ff <= 1'b1;
      end
   end

   // Permit bit, changed only by software or reset
   always_ff @(posedge clk_sys) begin
      if (rst || evt) begin
         permit_ff <= 1'b0;
      end else if (wr_ctl) begin
         permit_ff <= pwdata[`NVA_CTL_PERMIT];
      end
   end

   // Abort flag; the hardware set wins over a software write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         abort_ff <= 1'b0;
      end else if (evt && launch_ff) begin
         abort_ff <= 1'b1;
      end else if (wr_ctl) begin
         abort_ff <= pwdata[`NVA_CTL_ABORT];
      end
   end

   // Power-up timer, restarted by brown-out
   always_ff @(posedge clk_sys) begin
      if (rst || brownout_reset) begin
         pwrt_ff <= PW'(PWRT_CYCLES);
      end else if (pwrt_ff != '0) begin
         pwrt_ff <= pwrt_ff - PW'(1);
      end
   end

   // Unlock sequencer: key1, key2, then launch, within the gap
   always_comb begin
      nxt_ulk = ulk_ff;
      if (acc_wr) begin
         case (ulk_ff)
            NVA_ULK_IDLE:
               nxt_ulk = (wr_ulk && pwdata[7:0] == `NVA_UNLOCK_KEY1) ?
                         NVA_ULK_SAW1 : NVA_ULK_IDLE;
            NVA_ULK_SAW1:
               nxt_ulk = (wr_ulk && pwdata[7:0] == `NVA_UNLOCK_KEY2) ?
                         NVA_ULK_ARMED : NVA_ULK_IDLE;
            default: nxt_ulk = NVA_ULK_IDLE;
         endcase
      end else if (ulk_ff != NVA_ULK_IDLE &&
                   ulk_gap_ff == `NVA_UNLOCK_GAP) begin
         nxt_ulk = NVA_ULK_IDLE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || evt) begin
         ulk_ff     <= NVA_ULK_IDLE;
         ulk_gap_ff <= 4'h0;
      end else begin
         ulk_ff     <= nxt_ulk;
         ulk_gap_ff <= (acc_wr || nxt_ulk == NVA_ULK_IDLE) ? 4'h0 :
                       ulk_gap_ff + 4'h1;
      end
   end

   // Program launch, gated by permit, unlock and power-up timer
   assign launch = wr_ctl && pwdata[`NVA_CTL_PROGRAM] && !launch_ff &&
                   permit_ff && (ulk_ff == NVA_ULK_ARMED) &&
                   (pwrt_ff == '0) && !evt;
   assign done   = (wr_ff == NVA_WR_PROG) && (wcnt_ff == '0) && !evt;

   always_ff @(posedge clk_sys) begin
      if (rst || evt) begin
         launch_ff <= 1'b0;
      end else if (done) begin
         launch_ff <= 1'b0;
      end else if (launch) begin
         launch_ff <= 1'b1;
      end
   end

   // Self-timed write: erase phase, then program phase
   always_ff @(posedge clk_sys) begin
      if (rst || evt) begin
         wr_ff   <= NVA_WR_IDLE;
         wcnt_ff <= '0;
         wa_ff   <= '0;
         wd_ff   <= `NVA_RST_BYTE;
      end else begin
         case (wr_ff)
            NVA_WR_IDLE: begin
               if (launch) begin
                  wr_ff   <= NVA_WR_ERASE;
                  wcnt_ff <= CW'(ERASE_CYC - 1);
                  wa_ff   <= loc_ff;
                  wd_ff   <= data_ff;
               end
            end
            NVA_WR_ERASE: begin
               if (wcnt_ff == '0) begin
                  wr_ff   <= NVA_WR_PROG;
                  wcnt_ff <= CW'(PROG_CYC - 1);
               end else begin
                  wcnt_ff <= wcnt_ff - CW'(1);
               end
            end
            NVA_WR_PROG: begin
               if (wcnt_ff == '0) begin
                  wr_ff <= NVA_WR_IDLE;
               end else begin
                  wcnt_ff <= wcnt_ff - CW'(1);
               end
            end
            default: wr_ff <= NVA_WR_IDLE;
         endcase
      end
   end

   assign arr_we    = ((wr_ff == NVA_WR_ERASE) && (wcnt_ff == '0) && !evt) ||
                      done;
   assign arr_wdata = (wr_ff == NVA_WR_ERASE) ? `NVA_ERASED_BYTE : wd_ff;

   // Done flag: sticky, set wins over software clear
   always_ff @(posedge clk_sys) begin
      if (rst || evt) begin
         done_flag_ff <= 1'b0;
      end else if (done) begin
         done_flag_ff <= 1'b1;
      end else if (wr_irq) begin
         done_flag_ff <= pwdata[`NVA_IRQ_DONE];
      end
   end

   // Programmer read path, zeroes while protected
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prot_s1_ff   <= 1'b0;
         prot_s2_ff   <= 1'b0;
         pga_s1_ff    <= '0;
         pga_s2_ff    <= '0;
         pgm_rdata_ff <= `NVA_RST_BYTE;
      end else begin
         prot_s1_ff   <= data_protect_pin;
         prot_s2_ff   <= prot_s1_ff;
         pga_s1_ff    <= pgm_addr_pin;
         pga_s2_ff    <= pga_s1_ff;
         pgm_rdata_ff <= prot_s2_ff ? `NVA_RST_BYTE : arr_rd_b;
      end
   end

   nva_array #(
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_array (
      .clk_sys   (clk_sys),
      .we        (arr_we),
      .wr_addr   (wa_ff),
      .wr_data   (arr_wdata),
      .rd_addr_a (loc_ff),
      .rd_data_a (arr_rd_a),
      .rd_addr_b (pga_s2_ff),
      .rd_data_b (arr_rd_b)
   );

   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
   assign pgm_rdata        = pgm_rdata_ff;
   assign nv_done_irq_flag = done_flag_ff;
   assign write_busy       = launch_ff;

   // Checks
   logic [CW-1:0] busy_len_ff;
   always_ff @(posedge clk_sys) begin
      if (rst || !launch_ff) begin
         busy_len_ff <= '0;
      end else begin
         busy_len_ff <= busy_len_ff + CW'(1);
      end
   end

   sequence s_launch;
      launch;
   endsequence
   sequence s_finish;
      done ##1 (!launch_ff && done_flag_ff);
   endsequence

   property p_len;
      @(posedge clk_sys) disable iff (rst)
      done |-> busy_len_ff == CW'(WRITE_CYCLES - 1);
   endproperty
   a_len: assert property (p_len) else $error("write length wrong");

   property p_launch;
      @(posedge clk_sys) disable iff (rst)
      s_launch |=> launch_ff && wr_ff == NVA_WR_ERASE;
   endproperty
   a_launch: assert property (p_launch) else $error("launch lost");

   property p_finish;
      @(posedge clk_sys) disable iff (rst)
      done |-> s_finish;
   endproperty
   a_finish: assert property (p_finish) else $error("done bad");

   property p_fetch;
      @(posedge clk_sys) disable iff (rst)
      fetch_ff && !evt |=> !fetch_ff && data_ff == $past(arr_rd_a);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch bad");

   property p_permit;
      @(posedge clk_sys) disable iff (rst)
      wr_ctl && !permit_ff && !launch_ff |=> !launch_ff;
   endproperty
   a_permit: assert property (p_permit) else $error("no permit");

   property p_keep_permit;
      @(posedge clk_sys) disable iff (rst)
      permit_ff && !wr_ctl && !evt |=> permit_ff;
   endproperty
   a_keep_permit: assert property (p_keep_permit)
      else $error("permit lost");

   property p_abort;
      @(posedge clk_sys) disable iff (rst)
      evt && launch_ff |=> abort_ff && !launch_ff && data_ff == 8'h00 &&
                          loc_ff == '0;
   endproperty
   a_abort: assert property (p_abort) else $error("abort bad");

   property p_pwrt;
      @(posedge clk_sys) disable iff (rst)
      pwrt_ff != '0 |-> !launch && !launch_ff && !arr_we;
   endproperty
   a_pwrt: assert property (p_pwrt) else $error("pwrt write");

   property p_upper;
      @(posedge clk_sys) disable iff (rst)
      setup && !pwrite && (paddr == `NVA_OFS_CONTROL ||
         paddr == `NVA_OFS_UNLOCK) |=> prdata[31:4] == 28'h0 &&
         (paddr != `NVA_OFS_UNLOCK || prdata == 32'h0);
   endproperty
   a_upper: assert property (p_upper) else $error("zero bits");

   property p_prot;
      @(posedge clk_sys) disable iff (rst)
      prot_s2_ff |=> pgm_rdata == 8'h00;
   endproperty
   a_prot: assert property (p_prot) else $error("protect leak");
endmodule : nva_top

`default_nettype wire

/* File: core/nva_dummy_end.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: bench/tb_data_eeprom_access.sv */
// Self-checking bench for the nonvolatile data access block.
// Assumes nva_pkg and nva_consts.svh are compiled and on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "nva_consts.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
   errors++; $display("[FAIL] %0t got %0h expected %0h", $time, \
   (got), (exp)); end end

module tb_data_eeprom_access;
   import nva_pkg::*;
   localparam int WRC  = 8;
   localparam int PWRT = 20;
   localparam logic [7:0] DAT = `NVA_OFS_DATA;
   localparam logic [7:0] LOC = `NVA_OFS_LOCATION;
   localparam logic [7:0] CTL = `NVA_OFS_CONTROL;
   localparam logic [7:0] UNL = `NVA_OFS_UNLOCK;
   localparam logic [7:0] IRQ = `NVA_OFS_IRQFLAGS;

   logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, last_rd;
   logic        last_err, cpu_sleep, data_protect_pin;
   logic [2:0]  rst_ev;
   logic [7:0]  pgm_addr_pin;
   nva_byte_t   pgm_rdata;
   logic        nv_done_irq_flag, write_busy;
   int          errors, checks_done, n;
   logic [7:0]  la [3] = '{8'h00, 8'hFF, 8'h3C};
   logic [7:0]  da [3] = '{8'h5A, 8'hC3, 8'hA5};

   nva_top #(.WRITE_CYCLES(WRC), .PWRT_CYCLES(PWRT)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .master_clear_reset(rst_ev[0]), .watchdog_timeout_reset(rst_ev[1]),
      .brownout_reset(rst_ev[2]), .cpu_sleep(cpu_sleep),
      .data_protect_pin(data_protect_pin), .pgm_addr_pin(pgm_addr_pin),
      .pgm_rdata(pgm_rdata), .nv_done_irq_flag(nv_done_irq_flag),
      .write_busy(write_busy));

   always #50 clk_sys = ~clk_sys;

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         errors++;
         $display("[FAIL] %0t no ready from slave", $time);
      end
      last_rd = prdata;
      last_err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      `CHK(last_rd, exp)
   endtask : chk_rd

   // Full unlock sequence with permit set beforehand
   task automatic start_write(input logic [7:0] a, input logic [7:0] d);
      wr(LOC, {24'h0, a});
      wr(DAT, {24'h0, d});
      wr(CTL, 32'h04);
      wr(UNL, 32'h55);
      wr(UNL, 32'hAA);
      wr(CTL, 32'h06);
   endtask : start_write

   // Counts busy cycles after the launch edge, bounded
   task automatic wait_idle(output int cnt);
      cnt = 0;
      @(posedge clk_sys);
      while (write_busy === 1'b1 && cnt < 200) begin
         cnt++;
         @(posedge clk_sys);
      end
      if (cnt >= 200) begin
         errors++;
         $display("[FAIL] %0t write never finished", $time);
      end
   endtask : wait_idle

   task automatic fetch(input logic [7:0] a, input logic [7:0] exp);
      wr(LOC, {24'h0, a});
      wr(CTL, 32'h01);
      chk_rd(DAT, {24'h0, exp});
   endtask : fetch

   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      wrap_up();
   end

   initial begin
      clk_sys = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; rst_ev = 3'b000;
      cpu_sleep = 1'b0; data_protect_pin = 1'b0; pgm_addr_pin = 8'h00;
      errors = 0; checks_done = 0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      // Launch attempt while the power-up timer still runs
      wr(CTL, 32'h04); wr(UNL, 32'h55); wr(UNL, 32'hAA); wr(CTL, 32'h06);
      @(posedge clk_sys);
      `CHK(write_busy, 1'b0)
      chk_rd(CTL, 32'h04);
      chk_rd(DAT, 32'h0);
      chk_rd(LOC, 32'h0);
      chk_rd(IRQ, 32'h0);
      wr(UNL, 32'hFF);
      chk_rd(UNL, 32'h0);
      wr(CTL, 32'hF0);
      chk_rd(CTL, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      `CHK(last_err, 1'b1)
      `CHK(last_rd, 32'h0)
      repeat (PWRT) @(posedge clk_sys);
      // Writes at both ends and in the middle of the address range
      for (int i = 0; i < 3; i++) begin
         start_write(la[i], da[i]);
         wait_idle(n);
         `CHK(n, WRC)
         `CHK(nv_done_irq_flag, 1'b1)
         chk_rd(CTL, 32'h04);
         chk_rd(IRQ, 32'h80);
         wr(IRQ, 32'h0);
         chk_rd(IRQ, 32'h0);
      end
      for (int i = 0; i < 3; i++) begin
         fetch(la[i], da[i]);
         chk_rd(CTL, 32'h00);
      end
      wr(DAT, 32'h11);
      chk_rd(DAT, 32'h11);
      // Programmer view with and without protection
      pgm_addr_pin <= 8'hFF;
      repeat (5) @(posedge clk_sys);
      `CHK(pgm_rdata, 8'hC3)
      data_protect_pin <= 1'b1;
      repeat (5) @(posedge clk_sys);
      `CHK(pgm_rdata, 8'h00)
      fetch(8'hFF, 8'hC3);
      data_protect_pin <= 1'b0;
      // Permit cleared by software mid-write; launch bit stays set
      start_write(8'h3C, 8'h77);
      wr(CTL, 32'h0);
      chk_rd(CTL, 32'h02);
      wait_idle(n);
      fetch(8'h3C, 8'h77);
      // Broken unlock sequences, permit missing first
      for (int k = 0; k < 4; k++) begin
         wr(CTL, (k == 0) ? 32'h0 : 32'h04);
         wr(UNL, (k == 2) ? 32'hAA : 32'h55);
         if (k == 1) wr(DAT, 32'hEE);
         wr(UNL, (k == 2) ? 32'h55 : 32'hAA);
         if (k == 3) repeat (10) @(posedge clk_sys);
         wr(CTL, 32'h06);
         @(posedge clk_sys);
         `CHK(write_busy, 1'b0)
      end
      fetch(8'h3C, 8'h77);
      // Reset events in mid-write
      for (int e = 0; e < 3; e++) begin
         start_write(8'h3C, 8'h99);
         repeat (3) @(posedge clk_sys);
         rst_ev[e] <= 1'b1;
         @(posedge clk_sys);
         rst_ev <= 3'b000;
         repeat (3) @(posedge clk_sys);
         `CHK(write_busy, 1'b0)
         `CHK(nv_done_irq_flag, 1'b0)
         chk_rd(CTL, 32'h08);
         chk_rd(DAT, 32'h0);
         chk_rd(LOC, 32'h0);
         wr(CTL, 32'h0);
         chk_rd(CTL, 32'h0);
         repeat (PWRT + 5) @(posedge clk_sys);
      end
      // Watchdog while asleep leaves the write alone
      cpu_sleep <= 1'b1;
      start_write(8'h3C, 8'h99);
      repeat (3) @(posedge clk_sys);
      rst_ev[1] <= 1'b1;
      @(posedge clk_sys);
      rst_ev <= 3'b000;
      wait_idle(n);
      chk_rd(CTL, 32'h04);
      cpu_sleep <= 1'b0;
      fetch(8'h3C, 8'h99);
      wrap_up();
   end
endmodule : tb_data_eeprom_access
`undef CHK
`default_nettype wire
